// ### design/ldoc_freq_mon.sv
// Purpose: counts oscillator edges within a time base window
// Assumes: osc_tick is a one-cycle pulse per oscillator period
// Notes:   result updates once per window
`timescale 1ns/100ps
module ldoc_freq_mon #(
  parameter int WINDOW = 25000
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // oscillator and limits
  input  wire logic        osc_tick,
  input  wire logic [15:0] limit_hi,
  input  wire logic [15:0] limit_lo,
  // results
  output logic      [15:0] count_reg,
  output logic             too_high_reg,
  output logic             too_low_reg
);
  logic [15:0] base_reg;
  logic [15:0] edges_reg;
  logic        window_end;

  assign window_end = (base_reg == 16'(WINDOW - 1));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      base_reg <= 16'h0000;
    end else if (window_end) begin
      base_reg <= 16'h0000;
    end else begin
      base_reg <= base_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      edges_reg <= 16'h0000;
    end else if (window_end) begin
      edges_reg <= 16'h0000;
    end else if (osc_tick && edges_reg != 16'hffff) begin
      edges_reg <= edges_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg    <= 16'h0000;
      too_high_reg <= 1'b0;
      too_low_reg  <= 1'b0;
    end else if (window_end) begin
      count_reg    <= edges_reg;
      too_high_reg <= edges_reg > limit_hi;
      too_low_reg  <= edges_reg < limit_lo;
    end
  end
endmodule

// ### design/ldoc_top.sv
// Purpose: configuration lock and diagnostic output driver control
// Assumes: apb register access; error sources synchronous to clk
// Notes:   lock bits are one-time and cleared only by reset
// Function
// - lock offers write-only or read-and-write choices
// - any lock refuses every later register write
// - lock cannot be cleared by any access
// - read lock returns zero data except from the lock register; write lock keeps reads
// - diagnostic output select: none, positive pair, negative pair, all
// - per-error enable for output diagnostic indication
// - enabled error with diagnostics on disables selected drivers
// - over-current disables that output driver
// - software enables and clears interrupt events
// - oscillator frequency counted, alarm above or below limits
// - shared pin is address strap or interrupt output
// - ecc and parity failures reported as diagnostic errors
// - static alarms stay until reset, temporary follow source
// - each flag has its own interrupt enable
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
module ldoc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // error sources, level per error type
  input  wire logic [3:0]  err_src,
  input  wire logic        ecc_fail,
  input  wire logic        parity_fail,
  input  wire logic        osc_tick,
  // over-current per driver: sine_pos, cosine_pos, sine_neg, cosine_neg
  input  wire logic [3:0]  over_current,
  // shared address/interrupt pin
  input  wire logic        addr_strap_irq_pin_in,
  output logic             addr_strap_irq_pin_out,
  output logic             addr_strap_irq_pin_oe,
  output logic             addr_strap_level,
  // analog output driver enables
  output logic             sine_pos_out_clk_en,
  output logic             cosine_pos_out_dat_en,
  output logic             sine_neg_out_en,
  output logic             cosine_neg_out_en,
  // interrupt
  output logic             irq
);
  logic        lock_wr_reg;
  logic        lock_rw_reg;
  logic [1:0]  sel_reg;
  logic        diag_on_reg;
  logic        if_irq_reg;
  logic [7:0]  diag_en_reg;
  logic [7:0]  irq_en_reg;
  logic [7:0]  status_reg;
  logic [7:0]  mask_reg;
  logic [15:0] osc_hi_reg;
  logic [15:0] osc_lo_reg;
  logic [7:0]  static_reg;
  logic [3:0]  ocp_reg;
  logic [3:0]  driver_en_reg;
  logic        strap_done_reg;
  logic        strap_reg;
  logic [15:0] osc_count;
  logic        osc_high;
  logic        osc_low;
  logic [7:0]  err_raw;
  logic [7:0]  err_live;
  logic [7:0]  err_rise;
  logic [7:0]  err_prev_reg;
  logic        access;
  logic        wr_ok;
  logic        diag_hit;
  logic [3:0]  diag_off;
  logic [31:0] rd_next;
  logic        unmapped;

  ldoc_freq_mon #(
    .WINDOW       (ldoc_pkg::WINDOW_CYC)
  ) i_ldoc_freq_mon (
    .clk          (clk),
    .reset        (reset),
    .osc_tick     (osc_tick),
    .limit_hi     (osc_hi_reg),
    .limit_lo     (osc_lo_reg),
    .count_reg    (osc_count),
    .too_high_reg (osc_high),
    .too_low_reg  (osc_low)
  );

  assign err_raw = {osc_low, osc_high, parity_fail, ecc_fail, err_src};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      static_reg <= 8'h00;
    end else begin
      static_reg <= static_reg | (err_raw & ldoc_pkg::STATIC_MASK);
    end
  end

  assign err_live = (err_raw & ~ldoc_pkg::STATIC_MASK) | static_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_prev_reg <= 8'h00;
    end else begin
      err_prev_reg <= err_live;
    end
  end

  assign err_rise = err_live & ~err_prev_reg;

  // apb decode: zero wait states
  assign access   = psel && penable;
  assign pready   = 1'b1;
  assign wr_ok    = access && pwrite && !lock_wr_reg && !lock_rw_reg;
  assign unmapped = (paddr > ldoc_pkg::OFF_ERR_LIVE) || (paddr[1:0] != 2'b00);
  assign pslverr  = access && (unmapped || (pwrite && (lock_wr_reg || lock_rw_reg))
                    || (!pwrite && lock_rw_reg));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_wr_reg <= 1'b0;
      lock_rw_reg <= 1'b0;
    end else if (wr_ok && paddr == ldoc_pkg::OFF_LOCK) begin
      lock_wr_reg <= lock_wr_reg | pwdata[ldoc_pkg::LOCK_WR_BIT];
      lock_rw_reg <= lock_rw_reg | pwdata[ldoc_pkg::LOCK_RW_BIT];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sel_reg     <= ldoc_pkg::SEL_NONE;
      diag_on_reg <= 1'b0;
      if_irq_reg  <= 1'b0;
    end else if (wr_ok && paddr == ldoc_pkg::OFF_DIAG_CFG) begin
      sel_reg     <= pwdata[ldoc_pkg::SEL_LSB +: 2];
      diag_on_reg <= pwdata[ldoc_pkg::DIAG_ON_BIT];
      if_irq_reg  <= pwdata[ldoc_pkg::IF_IRQ_BIT];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      diag_en_reg <= ldoc_pkg::DIAG_EN_RST;
    end else if (wr_ok && paddr == ldoc_pkg::OFF_DIAG_EN) begin
      diag_en_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_en_reg <= ldoc_pkg::IRQ_EN_RST;
    end else if (wr_ok && paddr == ldoc_pkg::OFF_IRQ_EN) begin
      irq_en_reg <= pwdata[7:0];
    end
  end

  // interrupt output mask
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_reg <= ldoc_pkg::IRQ_MASK_RST;
    end else if (wr_ok && paddr == ldoc_pkg::OFF_IRQ_MASK) begin
      mask_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_hi_reg <= ldoc_pkg::OSC_HI_RST;
    end else if (wr_ok && paddr == ldoc_pkg::OFF_OSC_HI) begin
      osc_hi_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_lo_reg <= ldoc_pkg::OSC_LO_RST;
    end else if (wr_ok && paddr == ldoc_pkg::OFF_OSC_LO) begin
      osc_lo_reg <= pwdata[15:0];
    end
  end

  // sticky events, write one clears
  // set wins over clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_reg <= 8'h00;
    end else if (wr_ok && paddr == ldoc_pkg::OFF_STATUS) begin
      status_reg <= (status_reg & ~pwdata[7:0]) | (err_rise & irq_en_reg);
    end else begin
      status_reg <= status_reg | (err_rise & irq_en_reg);
    end
  end

  assign irq = |(status_reg & mask_reg);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ocp_reg <= 4'h0;
    end else begin
      ocp_reg <= ocp_reg | over_current;
    end
  end

  assign diag_hit = diag_on_reg && |(err_live & diag_en_reg);
  always_comb begin
    diag_off = 4'h0;
    if (diag_hit) begin
      unique case (sel_reg)
        ldoc_pkg::SEL_NONE: diag_off = 4'h0;
        ldoc_pkg::SEL_POS:  diag_off = 4'h3;
        ldoc_pkg::SEL_NEG:  diag_off = 4'hc;
        ldoc_pkg::SEL_ALL:  diag_off = 4'hf;
      endcase
    end
  end

  // live over-current too, so a short cuts the driver at the next edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      driver_en_reg <= 4'h0;
    end else begin
      driver_en_reg <= ~(diag_off | ocp_reg | over_current);
    end
  end

  assign sine_pos_out_clk_en   = driver_en_reg[0];
  assign cosine_pos_out_dat_en = driver_en_reg[1];
  assign sine_neg_out_en       = driver_en_reg[2];
  assign cosine_neg_out_en     = driver_en_reg[3];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_done_reg <= 1'b0;
      strap_reg      <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      strap_reg      <= addr_strap_irq_pin_in;
    end
  end

  assign addr_strap_level       = strap_reg;
  assign addr_strap_irq_pin_out = 1'b0;
  assign addr_strap_irq_pin_oe  = if_irq_reg && irq;

  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (paddr)
      ldoc_pkg::OFF_LOCK:     rd_next = {30'h0, lock_rw_reg, lock_wr_reg};
      ldoc_pkg::OFF_DIAG_CFG: rd_next = {28'h0, if_irq_reg, diag_on_reg, sel_reg};
      ldoc_pkg::OFF_DIAG_EN:  rd_next = {24'h0, diag_en_reg};
      ldoc_pkg::OFF_IRQ_EN:   rd_next = {24'h0, irq_en_reg};
      ldoc_pkg::OFF_STATUS:   rd_next = {24'h0, status_reg};
      ldoc_pkg::OFF_IRQ_MASK: rd_next = {24'h0, mask_reg};
      ldoc_pkg::OFF_OSC_HI:   rd_next = {16'h0, osc_hi_reg};
      ldoc_pkg::OFF_OSC_LO:   rd_next = {16'h0, osc_lo_reg};
      ldoc_pkg::OFF_OSC_CNT:  rd_next = {16'h0, osc_count};
      ldoc_pkg::OFF_OCP:      rd_next = {28'h0, ocp_reg};
      ldoc_pkg::OFF_ERR_LIVE: rd_next = {24'h0, err_live};
      default:                rd_next = 32'h0000_0000;
    endcase
    if (lock_rw_reg && paddr != ldoc_pkg::OFF_LOCK) begin
      rd_next = 32'h0000_0000;
    end
  end

  // loaded in setup so read data stands through the access phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_next;
    end
  end
endmodule

// ### shared/ldoc_pkg.sv
// Purpose: constants for the lock and diagnostic output control block
// Assumes: apb slave, 32-bit data, one word per register
// Notes:   offsets are byte addresses
package ldoc_pkg;
  localparam int          ERR_W          = 8;
  localparam int          ADDR_W         = 12;
  // register offsets
  localparam logic [11:0] OFF_LOCK       = 12'h000;
  localparam logic [11:0] OFF_DIAG_CFG   = 12'h004;
  localparam logic [11:0] OFF_DIAG_EN    = 12'h008;
  localparam logic [11:0] OFF_IRQ_EN     = 12'h00c;
  localparam logic [11:0] OFF_STATUS     = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK   = 12'h014;
  localparam logic [11:0] OFF_OSC_HI     = 12'h018;
  localparam logic [11:0] OFF_OSC_LO     = 12'h01c;
  localparam logic [11:0] OFF_OSC_CNT    = 12'h020;
  localparam logic [11:0] OFF_OCP        = 12'h024;
  localparam logic [11:0] OFF_ERR_LIVE   = 12'h028;
  // lock register fields
  localparam int          LOCK_WR_BIT    = 0;
  localparam int          LOCK_RW_BIT    = 1;
  // diag config fields
  localparam int          SEL_LSB        = 0;
  localparam int          DIAG_ON_BIT    = 2;
  localparam int          IF_IRQ_BIT     = 3;
  // error bit positions
  localparam int          ERR_OSC_HI     = 6;
  localparam int          ERR_OSC_LO     = 7;
  localparam int          ERR_ECC        = 4;
  localparam int          ERR_PARITY     = 5;
  // static errors (stay until reset), others follow their source
  localparam logic [7:0]  STATIC_MASK    = 8'h30;
  // reset values
  localparam logic [7:0]  DIAG_EN_RST    = 8'hff;
  localparam logic [7:0]  IRQ_EN_RST     = 8'h00;
  localparam logic [7:0]  IRQ_MASK_RST   = 8'h00;
  localparam logic [15:0] OSC_HI_RST     = 16'hffff;
  localparam logic [15:0] OSC_LO_RST     = 16'h0000;
  // time base: 1 ms window at 25 MHz
  localparam int          CLK_HZ         = 25000000;
  localparam int          WINDOW_US      = 1000;
  localparam int          WINDOW_CYC     = CLK_HZ / 1000000 * WINDOW_US;
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_POS  = 2'b01,
    SEL_NEG  = 2'b10,
    SEL_ALL  = 2'b11
  } ldoc_sel_type;
endpackage

// ### test/ldoc_checker.sv
// Purpose: port checks for ldoc_top
// Assumes: zero wait apb slave
// Notes:   lock state rebuilt from bus traffic
`timescale 1ns/100ps
module ldoc_checker (
  // clock, reset, bus
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // pins
  input wire logic [3:0]  over_current,
  input wire logic        addr_strap_irq_pin_out,
  input wire logic        addr_strap_irq_pin_oe,
  input wire logic        irq,
  input wire logic        sine_pos_out_clk_en,
  input wire logic        cosine_neg_out_en
);
  logic wr_lock_reg;
  logic rw_lock_reg;
  wire  acc = psel && penable;
  wire  lock_wr = acc && pwrite && paddr == ldoc_pkg::OFF_LOCK && !pslverr;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_lock_reg <= 1'h0;
      rw_lock_reg <= 1'h0;
    end else if (lock_wr) begin
      wr_lock_reg <= wr_lock_reg | pwdata[ldoc_pkg::LOCK_WR_BIT];
      rw_lock_reg <= rw_lock_reg | pwdata[ldoc_pkg::LOCK_RW_BIT];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence lock_set_s;
    lock_wr && pwdata[1:0] != 2'h0;
  endsequence
  sequence wr_acc_s;
    acc && pwrite;
  endsequence
  write_refused_a: assert property ((wr_lock_reg || rw_lock_reg) && acc && pwrite |-> pslverr)
    else $error("write accepted while locked");
  lock_sticky_a: assert property (wr_lock_reg && acc && !pwrite && paddr == 12'h000 |-> prdata[0])
    else $error("write lock bit lost");
  read_blocked_a: assert property (rw_lock_reg && acc && !pwrite && paddr != 12'h000
    |-> prdata == 32'h0 && pslverr) else $error("read allowed under read lock");
  read_open_a: assert property (wr_lock_reg && !rw_lock_reg && acc && !pwrite
    && paddr <= 12'h028 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("read refused");
  lock_at_once_a: assert property (lock_set_s ##[1:3] wr_acc_s |-> pslverr)
    else $error("write after lock accepted");
  ocp_latch_a: assert property (over_current[0] |=> !sine_pos_out_clk_en [*8])
    else $error("driver on after over-current");
  ocp_neg_a: assert property (over_current[3] |=> !cosine_neg_out_en)
    else $error("negative driver on after over-current");
  pin_out_a: assert property (addr_strap_irq_pin_oe |-> irq && !addr_strap_irq_pin_out)
    else $error("shared pin pulled without interrupt");
endmodule
bind ldoc_top ldoc_checker i_ldoc_checker (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .prdata(prdata), .over_current(over_current), .addr_strap_irq_pin_out(addr_strap_irq_pin_out),
  .addr_strap_irq_pin_oe(addr_strap_irq_pin_oe), .irq(irq),
  .sine_pos_out_clk_en(sine_pos_out_clk_en), .cosine_neg_out_en(cosine_neg_out_en));

// ### test/ldoc_pin_model.sv
// Purpose: board side of the shared strap and interrupt pin
// Assumes: strap resistor pulls the idle wire
// Notes:   wire low while the block pulls it, at the strap level otherwise
`timescale 1ns/100ps
module ldoc_pin_model (
  // from the block
  input  wire logic oe,
  input  wire logic out,
  // strap level and resolved wire
  input  wire logic strap_high,
  output logic      pin
);
  assign pin = oe ? out : strap_high;
endmodule

// ### test/tb_ldoc_top.sv
// Purpose: self-checking bench for ldoc_top
// Assumes: zero wait apb, 25 MHz clock
// Notes:   oscillator ticks driven only in the frequency test
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_ldoc_top;
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, osc_tick = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, se, pin, pin_out, pin_oe, strap_lvl, irq;
  logic        ecc_fail = 1'h0, parity_fail = 1'h0, strap = 1'h1;
  logic [3:0]  err_src = 4'h0, over_current = 4'h0, drv;
  int          err_total = 0, total_checks = 0;
  always #20 clk = ~clk;
  ldoc_top i_ldoc_top (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .err_src(err_src), .ecc_fail(ecc_fail), .parity_fail(parity_fail),
    .osc_tick(osc_tick), .over_current(over_current), .addr_strap_irq_pin_in(pin),
    .addr_strap_irq_pin_out(pin_out), .addr_strap_irq_pin_oe(pin_oe),
    .addr_strap_level(strap_lvl), .sine_pos_out_clk_en(drv[0]),
    .cosine_pos_out_dat_en(drv[1]), .sine_neg_out_en(drv[2]), .cosine_neg_out_en(drv[3]),
    .irq(irq));
  ldoc_pin_model i_ldoc_pin_model (.oe(pin_oe), .out(pin_out), .strap_high(strap), .pin(pin));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      err_total++;
      wrap_up();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    bus(1'h1, a, d);
    `CHK("write error", e, se)
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] d, input logic e);
    bus(1'h0, a, 32'h0);
    `CHK("read data", d, rd)
    `CHK("read error", e, se)
  endtask
  task automatic do_reset;
    reset <= 1'h1;
    cyc(10);
    reset <= 1'h0;
  endtask
  task automatic t_reset;
    rc(ldoc_pkg::OFF_DIAG_EN, 32'hff, 1'h0);
    rc(ldoc_pkg::OFF_IRQ_MASK, 32'h0, 1'h0);
    rc(ldoc_pkg::OFF_OSC_HI, 32'hffff, 1'h0);
    rc(12'h02c, 32'h0, 1'h1);
    `CHK("strap", 1'h1, strap_lvl)
    $display("test reset values done");
  endtask
  task automatic t_diag;
    logic [2:0] k;
    err_src <= 4'h1;
    for (k = 3'h0; k < 3'h4; k++) begin
      wr(ldoc_pkg::OFF_DIAG_CFG, {29'h0, 1'h1, k[1:0]}, 1'h0);
      cyc(3);
      `CHK("drivers", {~k[1], ~k[1], ~k[0], ~k[0]}, drv)
    end
    wr(ldoc_pkg::OFF_DIAG_EN, 32'hfe, 1'h0);
    cyc(3);
    `CHK("drivers", 4'hf, drv)
    wr(ldoc_pkg::OFF_DIAG_EN, 32'hff, 1'h0);
    wr(ldoc_pkg::OFF_DIAG_CFG, 32'h8, 1'h0);
    err_src <= 4'h0;
    $display("test diagnostic select done");
  endtask
  task automatic t_irq;
    wr(ldoc_pkg::OFF_IRQ_EN, 32'h2, 1'h0);
    wr(ldoc_pkg::OFF_IRQ_MASK, 32'h2, 1'h0);
    err_src <= 4'h2;
    cyc(2);
    err_src <= 4'h0;
    cyc(3);
    `CHK("irq", 1'h1, irq)
    `CHK("pin", 1'h0, pin)
    rc(ldoc_pkg::OFF_STATUS, 32'h2, 1'h0);
    rc(ldoc_pkg::OFF_ERR_LIVE, 32'h0, 1'h0);
    wr(ldoc_pkg::OFF_IRQ_MASK, 32'h0, 1'h0);
    cyc(1);
    `CHK("irq", 1'h0, irq)
    wr(ldoc_pkg::OFF_STATUS, 32'h2, 1'h0);
    rc(ldoc_pkg::OFF_STATUS, 32'h0, 1'h0);
    $display("test interrupt done");
  endtask
  task automatic t_static;
    ecc_fail <= 1'h1;
    parity_fail <= 1'h1;
    cyc(2);
    ecc_fail <= 1'h0;
    parity_fail <= 1'h0;
    cyc(2);
    rc(ldoc_pkg::OFF_ERR_LIVE, 32'h30, 1'h0);
    $display("test static errors done");
  endtask
  task automatic t_ocp;
    over_current <= 4'h9;
    cyc(1);
    over_current <= 4'h0;
    cyc(3);
    `CHK("drivers", 4'h6, drv)
    rc(ldoc_pkg::OFF_OCP, 32'h9, 1'h0);
    $display("test over-current done");
  endtask
  task automatic t_freq;
    int n;
    wr(ldoc_pkg::OFF_IRQ_EN, 32'hc0, 1'h0);
    wr(ldoc_pkg::OFF_IRQ_MASK, 32'h80, 1'h0);
    wr(ldoc_pkg::OFF_OSC_LO, 32'h5, 1'h0);
    n = 0;
    while (irq !== 1'h1 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    `CHK("low alarm", 1'h1, irq)
    rc(ldoc_pkg::OFF_OSC_CNT, 32'h0, 1'h0);
    wr(ldoc_pkg::OFF_OSC_LO, 32'h0, 1'h0);
    wr(ldoc_pkg::OFF_IRQ_MASK, 32'h40, 1'h0);
    wr(ldoc_pkg::OFF_OSC_HI, 32'h5, 1'h0);
    osc_tick <= 1'h1;
    n = 0;
    while (irq !== 1'h1 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    osc_tick <= 1'h0;
    `CHK("high alarm", 1'h1, irq)
    rc(ldoc_pkg::OFF_STATUS, 32'hc0, 1'h0);
    $display("test frequency alarm done");
  endtask
  task automatic t_lock;
    wr(ldoc_pkg::OFF_LOCK, 32'h1, 1'h0);
    wr(ldoc_pkg::OFF_DIAG_EN, 32'h0, 1'h1);
    rc(ldoc_pkg::OFF_DIAG_EN, 32'hff, 1'h0);
    wr(ldoc_pkg::OFF_LOCK, 32'h0, 1'h1);
    rc(ldoc_pkg::OFF_LOCK, 32'h1, 1'h0);
    strap <= 1'h0;
    do_reset;
    wr(ldoc_pkg::OFF_LOCK, 32'h2, 1'h0);
    `CHK("strap", 1'h0, strap_lvl)
    rc(ldoc_pkg::OFF_DIAG_EN, 32'h0, 1'h1);
    rc(ldoc_pkg::OFF_LOCK, 32'h2, 1'h1);
    $display("test lock done");
  endtask
  initial begin
    do_reset;
    t_reset;
    t_diag;
    t_irq;
    t_static;
    t_ocp;
    t_freq;
    t_lock;
    wrap_up;
  end
endmodule
